// *** mssa_cfg.svh ***
// Constants of the mission start and scratchpad access block.
// Assumes inclusion by bare name from the core and the CRC engine.
`ifndef MSSA_CFG_SVH
`define MSSA_CFG_SVH
// Command codes on the serial bus
`define MSSA_CMD_WRITE_SP 8'h0f
`define MSSA_CMD_READ_SP 8'haa
`define MSSA_CMD_COPY_SP 8'h99
`define MSSA_CMD_START 8'hcc
// Transfer status field positions
`define MSSA_ES_AA_BIT 7
`define MSSA_ES_ZERO_BIT 6
`define MSSA_ES_PF_BIT 5
`define MSSA_ES_END_MSB 4
// Last scratchpad offset
`define MSSA_SP_LAST 5'h1f
// Write-protected register pages during a mission
`define MSSA_REGPAGE_LO 16'h0200
`define MSSA_REGPAGE_HI 16'h023f
// Password cells that read back as zero
`define MSSA_PW_LO 16'h0228
`define MSSA_PW_HI 16'h0237
// Password length in bytes, minus one
`define MSSA_PW_LAST 4'h7
// Idle fill and copy done pattern
`define MSSA_FILL_ONES 8'hff
`define MSSA_COPY_DONE 8'haa
// Reflected CRC-16 polynomial
`define MSSA_CRC_POLY 16'ha001
`endif

// *** mssa_core.sv ***
// Mission start sequencing and scratchpad access over the serial bus.
// Assumes a bit layer on clk_i delivering bytes and a memory port.
`include "mssa_cfg.svh"
`default_nettype none
module mssa_core #(
  parameter int DELAY_W = 16 // Start delay width in bits; the delay counts minutes
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic frame_reset_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_partial_i,
  input wire logic tx_req_i,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  input wire logic pw_ok_i,
  input wire logic internal_busy_i,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [15:0] rd_addr_i,
  input wire logic [7:0] rd_data_i,
  output logic [7:0] rd_data_o,
  input wire logic od_set_i,
  input wire logic od_clear_i,
  output logic overdrive_select_o,
  input wire logic alarm_triggered_start_i,
  input wire logic logging_enable_i,
  input wire logic fast_sample_select_i,
  input wire logic [13:0] sample_rate_i,
  input wire logic [DELAY_W-1:0] start_delay_i,
  input wire logic sec_tick_i,
  input wire logic min_tick_i,
  input wire logic temp_alarm_i,
  input wire logic mission_stop_i,
  input wire logic clear_done_i,
  output logic mission_active_flag_o,
  output logic log_cleared_flag_o,
  output logic waiting_alarm_o,
  output logic meas_start_o,
  output logic log_entry_o,
  output logic timestamp_store_o,
  output logic mission_cnt_inc_o,
  output logic device_cnt_inc_o
);
  import mssa_pkg::*;

  mssa_crc_if crc_bus ();
  mssa_crc16 u_crc (.clk_i(clk_i), .resetn_i(resetn_i), .crc_io(crc_bus));

  mssa_cmd_state_t cmd_reg; // Command sequencer
  mssa_mis_state_t mis_reg; // Mission sequencer
  logic [7:0] sp_mem [0:31]; // Scratchpad storage
  logic [7:0] ta_low_reg; // target_addr_low
  logic [7:0] ta_high_reg; // target_addr_high
  logic aa_reg; // copy_accepted_flag
  logic pf_reg; // partial_byte_flag
  logic [4:0] end_reg; // Ending offset
  logic [5:0] ptr_reg; // Scratchpad pointer, 32 means full
  logic [3:0] cnt_reg; // Byte counter within a phase
  logic auth_ok_reg; // Echoed bytes matched
  logic [7:0] es_val; // Assembled status byte
  logic [15:0] ta_val; // Full target address
  logic start_req; // Start command accepted this cycle
  logic copy_ok; // All copy conditions met
  logic reg_page; // Target lies in register pages

  assign ta_val = {ta_high_reg, ta_low_reg};
  assign es_val = {aa_reg, 1'b0, pf_reg, end_reg};
  assign reg_page = (ta_val >= `MSSA_REGPAGE_LO) && (ta_val <= `MSSA_REGPAGE_HI);
  assign copy_ok = pw_ok_i && auth_ok_reg && (end_reg == `MSSA_SP_LAST)
                   && !(mission_active_flag_o && reg_page);
  assign start_req = (cmd_reg == SM_DUMMY) && rx_valid_i && pw_ok_i
                     && !mission_active_flag_o;

  // CRC feed: write stream in, read stream out
  always_comb begin
    crc_bus.clear = 1'b0;
    crc_bus.feed = 1'b0;
    crc_bus.data = rx_byte_i;
    // bytes enter the generator LSB first
    if (cmd_reg == CMD_IDLE && rx_valid_i) begin
      // cleared generator, then the command code
      crc_bus.clear = 1'b1;
      crc_bus.feed = 1'b1;
    end else if ((cmd_reg == WS_TA1 || cmd_reg == WS_TA2 || cmd_reg == WS_DATA)
                 && rx_valid_i) begin
      crc_bus.feed = 1'b1;
    end else if (cmd_reg == RS_SEND && tx_req_i && !cnt_reg[3] && !ptr_reg[5]) begin
      crc_bus.feed = 1'b1;
      crc_bus.data = tx_byte_next();
    end
  end

  // Byte the read stream sends next
  function automatic logic [7:0] tx_byte_next();
    logic [7:0] b;
    b = sp_mem[ptr_reg[4:0]];
    if (cnt_reg == 4'h0) begin
      b = ta_low_reg;
    end else if (cnt_reg == 4'h1) begin
      b = ta_high_reg;
    end else if (cnt_reg == 4'h2) begin
      b = es_val;
    end
    return b;
  endfunction

  // Command sequencer and scratchpad state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_reg <= CMD_IDLE;
      ta_low_reg <= 8'h00;
      ta_high_reg <= 8'h00;
      aa_reg <= 1'b0;
      pf_reg <= 1'b0;
      end_reg <= 5'h00;
      ptr_reg <= 6'h00;
      cnt_reg <= 4'h0;
      auth_ok_reg <= 1'b0;
    end else if (frame_reset_i && cmd_reg != CP_COPY) begin
      // Bus reset ends any command, except a running copy
      cmd_reg <= CMD_IDLE;
    end else begin
      case (cmd_reg)
        CMD_IDLE: begin
          cnt_reg <= 4'h0;
          if (rx_valid_i) begin
            case (rx_byte_i)
              `MSSA_CMD_WRITE_SP: cmd_reg <= WS_TA1;
              `MSSA_CMD_READ_SP: begin
                cmd_reg <= RS_SEND;
                ptr_reg <= {1'b0, ta_low_reg[4:0]};
              end
              `MSSA_CMD_COPY_SP: begin
                cmd_reg <= CP_AUTH;
                auth_ok_reg <= 1'b1;
              end
              `MSSA_CMD_START: cmd_reg <= SM_PW;
              default: cmd_reg <= CMD_HALT;
            endcase
          end
        end
        WS_TA1: begin
          if (rx_valid_i) begin
            ta_low_reg <= rx_byte_i;
            cmd_reg <= WS_TA2;
          end
        end
        WS_TA2: begin
          if (rx_valid_i) begin
            // low five bits are the offset
            ta_high_reg <= rx_byte_i;
            ptr_reg <= {1'b0, ta_low_reg[4:0]};
            end_reg <= ta_low_reg[4:0];
            pf_reg <= 1'b0;
            aa_reg <= 1'b0;
            cmd_reg <= WS_DATA;
          end
        end
        WS_DATA: begin
          if (rx_valid_i && !ptr_reg[5]) begin
            ptr_reg <= ptr_reg + 6'h01;
            end_reg <= ptr_reg[4:0];
          end
          if (rx_partial_i) begin
            pf_reg <= 1'b1;
          end
          if (tx_req_i && ptr_reg[5]) begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        RS_SEND: begin
          if (tx_req_i) begin
            if (cnt_reg < 4'h3) begin
              cnt_reg <= cnt_reg + 4'h1;
            end else if (!ptr_reg[5]) begin
              ptr_reg <= ptr_reg + 6'h01;
            end else if (cnt_reg != 4'hf) begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        CP_AUTH: begin
          if (rx_valid_i) begin
            // echo must match the three registers
            case (cnt_reg[1:0])
              2'b00: auth_ok_reg <= auth_ok_reg && (rx_byte_i == ta_low_reg);
              2'b01: auth_ok_reg <= auth_ok_reg && (rx_byte_i == ta_high_reg);
              default: auth_ok_reg <= auth_ok_reg && (rx_byte_i == es_val);
            endcase
            cnt_reg <= (cnt_reg == 4'h2) ? 4'h0 : cnt_reg + 4'h1;
            if (cnt_reg == 4'h2) begin
              cmd_reg <= CP_PW;
            end
          end
        end
        CP_PW: begin
          if (rx_valid_i) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == `MSSA_PW_LAST) begin
              ptr_reg <= {1'b0, ta_low_reg[4:0]};
              if (!pw_ok_i) begin
                cmd_reg <= CMD_HALT;
              end else if (copy_ok) begin
                aa_reg <= 1'b1;
                cmd_reg <= CP_COPY;
              end else begin
                cmd_reg <= CMD_HALT;
              end
            end
          end
        end
        CP_COPY: begin
          if (!internal_busy_i) begin
            ptr_reg <= ptr_reg + 6'h01;
            if (ptr_reg[4:0] == `MSSA_SP_LAST) begin
              cmd_reg <= CP_DONE;
            end
          end
        end
        SM_PW: begin
          if (rx_valid_i) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == `MSSA_PW_LAST) begin
              cmd_reg <= SM_DUMMY;
            end
          end
        end
        SM_DUMMY: begin
          if (rx_valid_i) begin
            cmd_reg <= CMD_HALT;
          end
        end
        CP_DONE, CMD_HALT: begin
          cnt_reg <= 4'h0;
        end
        default: cmd_reg <= CMD_HALT;
      endcase
    end
  end

  // Scratchpad array, one write port
  always_ff @(posedge clk_i) begin
    if (cmd_reg == WS_DATA && rx_valid_i && !ptr_reg[5] && !frame_reset_i) begin
      sp_mem[ptr_reg[4:0]] <= rx_byte_i;
    end
  end

  // Transmit side, one byte per master request
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_valid_o <= 1'b0;
      tx_byte_o <= `MSSA_FILL_ONES;
    end else begin
      tx_valid_o <= tx_req_i;
      tx_byte_o <= `MSSA_FILL_ONES;
      if (tx_req_i) begin
        case (cmd_reg)
          WS_DATA: begin
            if (ptr_reg[5] && cnt_reg == 4'h0) begin
              tx_byte_o <= ~crc_bus.crc[7:0];
            end else if (ptr_reg[5] && cnt_reg == 4'h1) begin
              tx_byte_o <= ~crc_bus.crc[15:8];
            end
          end
          RS_SEND: begin
            if (cnt_reg < 4'h3 || !ptr_reg[5]) begin
              tx_byte_o <= tx_byte_next();
            end else if (cnt_reg == 4'h3) begin
              tx_byte_o <= ~crc_bus.crc[7:0];
            end else if (cnt_reg == 4'h4) begin
              tx_byte_o <= ~crc_bus.crc[15:8];
            end
          end
          // Alternating pattern after a finished copy
          CP_DONE: tx_byte_o <= `MSSA_COPY_DONE;
          default: tx_byte_o <= `MSSA_FILL_ONES;
        endcase
      end
    end
  end

  // Memory write port driven by the copy
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_we_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 8'h00;
    end else begin
      // general memory copies allowed in mission
      // data lands from the target address
      mem_we_o <= (cmd_reg == CP_COPY) && !internal_busy_i;
      mem_addr_o <= {ta_val[15:5], ptr_reg[4:0]};
      mem_wdata_o <= sp_mem[ptr_reg[4:0]];
    end
  end

  // Read path filter
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= 8'h00;
    end else begin
      // password cells read back as zero
      rd_data_o <= (rd_addr_i >= `MSSA_PW_LO && rd_addr_i <= `MSSA_PW_HI) ? 8'h00 : rd_data_i;
    end
  end

  // Bus speed selection
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overdrive_select_o <= 1'b0;
    end else if (od_set_i) begin
      overdrive_select_o <= 1'b1;
    end else if (od_clear_i) begin
      overdrive_select_o <= 1'b0;
    end
  end

  // Mission status flags
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mission_active_flag_o <= 1'b0;
      log_cleared_flag_o <= 1'b0;
    end else if (start_req) begin
      // start sets active, clears cleared flag
      mission_active_flag_o <= 1'b1;
      log_cleared_flag_o <= 1'b0;
    end else begin
      if (mission_stop_i) begin
        mission_active_flag_o <= 1'b0;
      end
      if (clear_done_i && !mission_active_flag_o) begin
        log_cleared_flag_o <= 1'b1;
      end
    end
  end

  // Mission timing: delay and sample period counters
  logic [DELAY_W-1:0] delay_reg; // Minutes elapsed in delay
  logic [13:0] period_reg; // Ticks within a sample period
  logic rate_tick; // Tick at the selected rate
  logic period_end; // Sample period boundary
  assign rate_tick = fast_sample_select_i ? sec_tick_i : min_tick_i;
  // Rate zero treated as one
  assign period_end = rate_tick && (period_reg + 14'h0001 >= sample_rate_i);

  // Mission sequencer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mis_reg <= MIS_IDLE;
      delay_reg <= '0;
      period_reg <= 14'h0000;
      waiting_alarm_o <= 1'b0;
      meas_start_o <= 1'b0;
      log_entry_o <= 1'b0;
      timestamp_store_o <= 1'b0;
      mission_cnt_inc_o <= 1'b0;
      device_cnt_inc_o <= 1'b0;
    end else begin
      meas_start_o <= 1'b0;
      log_entry_o <= 1'b0;
      timestamp_store_o <= 1'b0;
      mission_cnt_inc_o <= 1'b0;
      device_cnt_inc_o <= 1'b0;
      if (rate_tick) begin
        period_reg <= period_end ? 14'h0000 : period_reg + 14'h0001;
      end
      case (mis_reg)
        MIS_IDLE: begin
          delay_reg <= '0;
          if (start_req) begin
            mis_reg <= MIS_DELAY;
          end
        end
        MIS_DELAY: begin
          if (delay_reg >= start_delay_i) begin
            period_reg <= 14'h0000;
            if (alarm_triggered_start_i && logging_enable_i) begin
              mis_reg <= MIS_WAIT_ALARM;
              waiting_alarm_o <= 1'b1;
            end else begin
              timestamp_store_o <= 1'b1;
              meas_start_o <= 1'b1;
              log_entry_o <= 1'b1;
              mission_cnt_inc_o <= 1'b1;
              device_cnt_inc_o <= 1'b1;
              mis_reg <= MIS_RUN;
            end
          end else if (min_tick_i) begin
            delay_reg <= delay_reg + 1'b1;
          end
        end
        MIS_WAIT_ALARM: begin
          if (temp_alarm_i) begin
            // first sample logged, mission count held
            log_entry_o <= 1'b1;
            waiting_alarm_o <= 1'b0;
            period_reg <= 14'h0000;
            mis_reg <= MIS_PRE_STAMP;
          end else if (period_end) begin
            meas_start_o <= 1'b1;
            device_cnt_inc_o <= 1'b1;
          end
        end
        MIS_PRE_STAMP: begin
          if (period_end) begin
            // stamp one period after the alarm
            timestamp_store_o <= 1'b1;
            meas_start_o <= 1'b1;
            log_entry_o <= 1'b1;
            mission_cnt_inc_o <= 1'b1;
            device_cnt_inc_o <= 1'b1;
            mis_reg <= MIS_RUN;
          end
        end
        MIS_RUN: begin
          if (period_end) begin
            // later entries follow the sample rate
            meas_start_o <= 1'b1;
            log_entry_o <= 1'b1;
            mission_cnt_inc_o <= 1'b1;
            device_cnt_inc_o <= 1'b1;
          end
        end
        default: mis_reg <= MIS_IDLE;
      endcase
      if (mission_stop_i) begin
        mis_reg <= MIS_IDLE;
        waiting_alarm_o <= 1'b0;
      end
    end
  end
endmodule // mssa_core
`default_nettype wire

// *** mssa_core_assertions.sv ***
// Port checks of the mission start and scratchpad block.
// Assumes one clock and resetn_i as asynchronous low reset.
`default_nettype none
module mssa_core_assertions (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic tx_req_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic [15:0] rd_addr_i,
  input wire logic [7:0] rd_data_i,
  input wire logic [7:0] rd_data_o,
  input wire logic od_set_i,
  input wire logic od_clear_i,
  input wire logic overdrive_select_o,
  input wire logic mem_we_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic mission_active_flag_o,
  input wire logic log_cleared_flag_o,
  input wire logic timestamp_store_o,
  input wire logic log_entry_o,
  input wire logic mission_cnt_inc_o,
  input wire logic device_cnt_inc_o
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_tx_answer: assert property (tx_req_i |=> tx_valid_o) else $error("slot unanswered");
  a_tx_idle: assert property (!tx_valid_o |-> tx_byte_o == 8'hff)
    else $error("idle byte not ones");
  a_pw_zero: assert property (rd_addr_i inside {[16'h0228:16'h0237]} |=>
    rd_data_o == 8'h00) else $error("password cell leaked");
  a_rd_pass: assert property (!(rd_addr_i inside {[16'h0228:16'h0237]}) |=>
    rd_data_o == $past(rd_data_i)) else $error("read data wrong");
  a_od_set: assert property (od_set_i |=> overdrive_select_o) else $error("no overdrive");
  a_od_hold: assert property (!od_set_i && !od_clear_i |=> $stable(overdrive_select_o))
    else $error("speed moved alone");
  a_start_flags: assert property ($rose(mission_active_flag_o) |-> !log_cleared_flag_o)
    else $error("cleared flag kept");
  a_cnt_pair: assert property (mission_cnt_inc_o |-> device_cnt_inc_o && log_entry_o)
    else $error("mission count alone");
  a_stamp_log: assert property (timestamp_store_o |-> log_entry_o && mission_cnt_inc_o)
    else $error("stamp without log");
  a_page_guard: assert property (mem_we_o && mission_active_flag_o |->
    !(mem_addr_o inside {[16'h0200:16'h023f]})) else $error("register page written");
endmodule // mssa_core_assertions
bind mssa_core mssa_core_assertions mssa_core_assertions_i (.*);
`default_nettype wire

// *** mssa_core_test.sv ***
// Self-checking bench of the mission start and scratchpad block.
// Assumes design, checker and master model compiled first.
`default_nettype none
module mssa_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, resetn_i = 1'b0;
  wire logic frame_reset_i, rx_partial_i, tx_req_i;
  logic rx_valid_i, pw_ok_i, internal_busy_i, od_set_i, od_clear_i, sec_tick_i, min_tick_i;
  logic alarm_triggered_start_i, logging_enable_i, fast_sample_select_i, temp_alarm_i;
  logic mission_stop_i, clear_done_i, tx_valid_o, mem_we_o, overdrive_select_o;
  logic mission_active_flag_o, log_cleared_flag_o, waiting_alarm_o, meas_start_o;
  logic log_entry_o, timestamp_store_o, mission_cnt_inc_o, device_cnt_inc_o;
  logic [7:0] rx_byte_i, tx_byte_o, mem_wdata_o, rd_data_i, rd_data_o;
  logic [15:0] mem_addr_o, rd_addr_i, start_delay_i, crc, c;
  logic [13:0] sample_rate_i;
  logic [2:0] ctl; // Frame reset, partial, read slot
  logic [7:0] dat [32];
  logic [23:0] expq [$]; // Expected bytes and copy writes
  int err_count = 0, compares = 0;
  assign {frame_reset_i, rx_partial_i, tx_req_i} = ctl;
  always #25 clk_i = ~clk_i;
  mssa_core mssa_core_i (.*);
  mssa_master_model mssa_master_model_i (.clk_i(clk_i), .rx_valid_o(rx_valid_i),
    .rx_byte_o(rx_byte_i), .ctl_o(ctl));
  task automatic chk(input logic [23:0] seen, input logic [23:0] want);
    compares++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED t=%0t saw %h want %h", $time, seen, want);
    end
  endtask
  // Reflected CRC-16, bits taken least significant first
  function automatic logic [15:0] step(input logic [15:0] s, input logic [7:0] b);
    s = s ^ {8'h00, b};
    for (int i = 0; i < 8; i++) s = s[0] ? (s >> 1) ^ 16'ha001 : s >> 1;
    return s;
  endfunction
  task automatic wr(input logic [7:0] b);
    crc = step(crc, b);
    mssa_master_model_i.send(b);
  endtask
  task automatic rd(input logic [7:0] b);
    crc = step(crc, b);
    expq.push_back({16'h0000, b});
    mssa_master_model_i.pulse(3'b001);
  endtask
  task automatic rd_crc;
    c = ~crc;
    rd(c[7:0]);
    rd(c[15:8]);
  endtask
  // Bus reset, then a command into a cleared CRC
  task automatic cmd(input logic [7:0] b);
    mssa_master_model_i.pulse(3'b100);
    crc = 16'h0000;
    wr(b);
  endtask
  // command, address and data all feed the CRC
  task automatic wscr(input logic [15:0] ta, input int n);
    cmd(8'h0f);
    wr(ta[7:0]);
    wr(ta[15:8]);
    for (int i = 0; i < n; i++) wr(dat[i]);
  endtask
  // password bytes are arbitrary, pw_ok_i passes them
  task automatic pw;
    repeat (8) wr(8'($urandom));
  endtask
  task automatic drain;
    for (int n = 0; n < 200 && expq.size() != 0; n++) @(negedge clk_i);
    chk(24'(expq.size()), 24'h0);
  endtask
  task automatic end_of_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Each result is matched with the oldest note
  always @(posedge clk_i) begin
    if (tx_valid_o === 1'b1) chk({16'h0000, tx_byte_o}, expq.pop_front());
    if (mem_we_o === 1'b1) chk({mem_addr_o, mem_wdata_o}, expq.pop_front());
  end
  // Random stalls and ticks; busy also delays copy writes
  always @(negedge clk_i) begin
    internal_busy_i = 1'($urandom % 2);
    sec_tick_i = 1'($urandom % 2);
    min_tick_i = 1'($urandom % 4 == 0);
  end
  // A hang counts as a mismatch
  initial begin
    #1ms;
    err_count++;
    end_of_test();
  end
  initial begin
    {pw_ok_i, internal_busy_i, od_set_i, od_clear_i, sec_tick_i, min_tick_i} = 6'h20;
    {alarm_triggered_start_i, logging_enable_i, fast_sample_select_i, temp_alarm_i} = 4'h6;
    {mission_stop_i, clear_done_i, rd_addr_i, rd_data_i} = 26'h0;
    sample_rate_i = 14'h0002;
    start_delay_i = 16'h0002;
    void'($urandom(32'h5f4e359e));
    foreach (dat[i]) dat[i] = 8'($urandom);
    repeat (6) @(negedge clk_i);
    resetn_i = 1'b1;
    chk({tx_byte_o, 7'h00, overdrive_select_o, 7'h00, mission_active_flag_o}, 24'hff0000);
    // offset 1Ch fills after four bytes
    wscr(16'h013c, 4);
    rd_crc();
    rd(8'hff);
    cmd(8'haa);
    rd(8'h3c);
    rd(8'h01);
    rd(8'h1f);
    for (int i = 0; i < 4; i++) rd(dat[i]);
    rd_crc();
    cmd(8'h99);
    wr(8'h3c);
    wr(8'h01);
    wr(8'h1f);
    for (int i = 0; i < 4; i++) expq.push_back({16'h013c + 16'(i), dat[i]});
    pw();
    drain();
    repeat (2) @(negedge clk_i);
    rd(8'haa);
    cmd(8'haa);
    rd(8'h3c);
    rd(8'h01);
    rd(8'h9f);
    // partial byte flagged, write clears accepted
    // master reads set flag as a failed write and stops reading
    wscr(16'h0000, 1);
    mssa_master_model_i.pulse(3'b010);
    cmd(8'haa);
    rd(8'h00);
    rd(8'h00);
    rd(8'h20);
    // copy refused while the end is short
    cmd(8'h99);
    wr(8'h00);
    wr(8'h00);
    wr(8'h20);
    pw();
    rd(8'hff);
    clear_done_i = 1'b1;
    @(negedge clk_i);
    clear_done_i = 1'b0;
    cmd(8'hcc);
    pw();
    wr(8'hff);
    repeat (2) @(negedge clk_i);
    chk(24'({mission_active_flag_o, log_cleared_flag_o}), 24'h2);
    for (int n = 0; n < 2000 && timestamp_store_o !== 1'b1; n++) @(negedge clk_i);
    chk(24'({timestamp_store_o, mission_cnt_inc_o, device_cnt_inc_o}), 24'h7);
    chk(24'({meas_start_o, log_entry_o}), 24'h3);
    // register page copy refused in mission
    wscr(16'h0200, 32);
    cmd(8'h99);
    wr(8'h00);
    wr(8'h02);
    wr(8'h1f);
    pw();
    rd(8'hff);
    foreach (dat[i]) begin
      rd_addr_i = 16'h0220 + 16'(i);
      rd_data_i = dat[i];
      @(negedge clk_i);
      chk(24'(rd_data_o), (i >= 8 && i < 24) ? 24'h0 : 24'(dat[i]));
    end
    od_set_i = 1'b1;
    @(negedge clk_i);
    od_set_i = 1'b0;
    chk(24'(overdrive_select_o), 24'h1);
    od_clear_i = 1'b1;
    @(negedge clk_i);
    od_clear_i = 1'b0;
    chk(24'(overdrive_select_o), 24'h0);
    // alarm start: device count only, log at alarm, stamp later
    mission_stop_i = 1'b1;
    alarm_triggered_start_i = 1'b1;
    @(negedge clk_i);
    mission_stop_i = 1'b0;
    cmd(8'hcc);
    pw();
    wr(8'hff);
    for (int n = 0; n < 2000 && device_cnt_inc_o !== 1'b1; n++) @(negedge clk_i);
    chk(24'({waiting_alarm_o, meas_start_o, log_entry_o, mission_cnt_inc_o}), 24'hc);
    temp_alarm_i = 1'b1;
    @(negedge clk_i);
    temp_alarm_i = 1'b0;
    chk(24'({waiting_alarm_o, log_entry_o, mission_cnt_inc_o, timestamp_store_o}), 24'h4);
    for (int n = 0; n < 2000 && timestamp_store_o !== 1'b1; n++) @(negedge clk_i);
    chk(24'({log_entry_o, mission_cnt_inc_o, device_cnt_inc_o}), 24'h7);
    drain();
    end_of_test();
  end
endmodule // mssa_core_test
`default_nettype wire

// *** mssa_crc16.sv ***
// Byte-wide CRC-16 engine, bits taken least significant first.
// Assumes clear with feed means restart from this byte alone.
`include "mssa_cfg.svh"
`default_nettype none
module mssa_crc16 (
  input wire logic clk_i,
  input wire logic resetn_i,
  mssa_crc_if.engine crc_io
);
  import mssa_pkg::*;
  logic [15:0] crc_reg; // Running remainder
  logic [15:0] crc_next; // Remainder after one byte

  // One whole byte per cycle, LSB first; clear drops the old remainder
  always_comb begin
    crc_next = (crc_io.clear ? 16'h0000 : crc_reg) ^ {8'h00, crc_io.data};
    for (int i = 0; i < 8; i++) begin
      crc_next = crc_next[0] ? ((crc_next >> 1) ^ `MSSA_CRC_POLY) : (crc_next >> 1);
    end
  end

  // Feed with clear starts over, so the command byte is not lost
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crc_reg <= 16'h0000;
    end else if (crc_io.feed) begin
      crc_reg <= crc_next;
    end else if (crc_io.clear) begin
      crc_reg <= 16'h0000;
    end
  end

  assign crc_io.crc = crc_reg;
endmodule // mssa_crc16
`default_nettype wire

// *** mssa_crc_if.sv ***
// Carrier between the command sequencer and its CRC-16 engine.
// Assumes both ends sit on the same clock.
`default_nettype none
interface mssa_crc_if;
  logic clear; // Restart from zero
  logic feed; // Shift in data this cycle
  logic [7:0] data; // Byte to shift in
  logic [15:0] crc; // Running value, not inverted
  modport engine(input clear, input feed, input data, output crc);
  modport user(output clear, output feed, output data, input crc);
endinterface
`default_nettype wire

// *** mssa_master_model.sv ***
// Serial bus master model: whole bytes, read slots, bus resets.
// Assumes the block's byte layer on the same clock.
`default_nettype none
module mssa_master_model (
  input wire logic clk_i,
  output var logic rx_valid_o,
  output var logic [7:0] rx_byte_o,
  output var logic [2:0] ctl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet bus at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    ctl_o = 3'h0;
  end
  // whole byte, then the inverse so stale data never matches
  task automatic send(input logic [7:0] b);
    @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_byte_o = b;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_byte_o = ~b;
  endtask
  // Frame reset, partial byte or read slot, one cycle each
  task automatic pulse(input logic [2:0] m);
    @(negedge clk_i);
    ctl_o = m;
    @(negedge clk_i);
    ctl_o = 3'h0;
  endtask
endmodule // mssa_master_model
`default_nettype wire

// *** mssa_pkg.sv ***
// Types shared by the mission start and scratchpad access block.
// Assumes the constants header sits in the include path.
`default_nettype none
package mssa_pkg;
  // Serial command sequencer states
  typedef enum logic [3:0] {
    CMD_IDLE = 4'b0000,
    WS_TA1 = 4'b0001,
    WS_TA2 = 4'b0010,
    WS_DATA = 4'b0011,
    RS_SEND = 4'b0100,
    CP_AUTH = 4'b0101,
    CP_PW = 4'b0110,
    CP_COPY = 4'b0111,
    CP_DONE = 4'b1000,
    SM_PW = 4'b1001,
    SM_DUMMY = 4'b1010,
    CMD_HALT = 4'b1011
  } mssa_cmd_state_t;
  // Mission sequencer states
  typedef enum logic [2:0] {
    MIS_IDLE = 3'b000,
    MIS_DELAY = 3'b001,
    MIS_WAIT_ALARM = 3'b010,
    MIS_PRE_STAMP = 3'b011,
    MIS_RUN = 3'b100
  } mssa_mis_state_t;
endpackage
`default_nettype wire
